// ==== design/dfm_defines.svh ====
// Register map, reset values and timing counts of the fault monitor.
`ifndef DFM_DEFINES_SVH
`define DFM_DEFINES_SVH
`define DFM_NUM_DEF 6
`define DFM_EV_PER_DEF 4
`define DFM_SLOT_DEF 5'h00
`define DFM_SLOT_THR 5'h01
`define DFM_SLOT_EVCFG 5'h05
`define DFM_SLOT_DELAY 5'h09
`define DFM_SLOT_STAT 5'h0D
`define DFM_SLOT_OC 5'h0E
`define DFM_GLOBAL_ADDR 8'hE0
`define DFM_LAMP_AMBER 2'h1
`define DFM_FMI_DEFAULT 5'h1F
`define DFM_FMI_LAST_STD 5'h15
`define DFM_FMI_EXISTS 5'h1F
`define DFM_OC_MAX 7'h7F
`define DFM_CLK_HZ 25000000
`define DFM_TICK_US 1000
`define DFM_TICK_CYC (`DFM_CLK_HZ / 1000000 * `DFM_TICK_US)
`define DFM_HOLD_S 5
`define DFM_HOLD_MS (`DFM_HOLD_S * 1000)
`define DFM_PERIOD_MS 1000
`endif

// ==== design/dfm_pkg.sv ====
// Types shared by the fault monitor and its neighbours.
package dfm_pkg;
  // What a diagnostic definition watches.
  typedef enum logic [2:0] {SRC_NONE, SRC_TC, SRC_SUPPLY, SRC_CPU, SRC_RXTO} dfm_src_t;
  // How the watched value is judged.
  typedef enum logic [1:0] {FT_MINMAX, FT_ABS, FT_STATE, FT_DMM} dfm_ftype_t;
  // Which message the transmit side must build.
  typedef enum logic {MSG_ACTIVE, MSG_PREV} dfm_kind_t;
  // Per-event reporting setup, laid out as in its register.
  typedef struct packed {
    logic latch;
    logic gen;
    logic [1:0] lamp;
    logic [4:0] fmi;
    logic [18:0] spn;
  } dfm_evcfg_t;
  // Definition setup, laid out as in its register.
  typedef struct packed {
    dfm_ftype_t ftype;
    logic [2:0] idx;
    dfm_src_t src;
  } dfm_defcfg_t;
  // Message request towards the transmit side.
  typedef struct packed {
    logic valid;
    dfm_kind_t kind;
    logic tp;
    logic [7:0] lamp;
    logic [4:0] count;
  } dfm_msg_t;
endpackage

// ==== design/dfm_monitor.sv ====
// Diagnostic fault monitor: six definitions, trouble-code state and message requests.
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/10ps
`include "dfm_defines.svh"
module dfm_monitor
  import dfm_pkg::*;
#(
  parameter int TICK_CYC = `DFM_TICK_CYC,
  parameter int HOLD_MS = `DFM_HOLD_MS,
  parameter int PERIOD_MS = `DFM_PERIOD_MS
)(
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic [15:0] SUPPLY_VALUE,
  input wire logic [15:0] CPU_TEMP,
  input wire logic [7:0] RX_TIMEOUT,
  input wire logic [95:0] TC_TEMP,
  input wire logic [113:0] TC_SPN,
  input wire logic CLR_ACTIVE_REQ,
  input wire logic CLR_PREV_REQ,
  input wire logic PREV_LIST_REQ,
  output dfm_msg_t MSG,
  input wire logic MSG_ACK,
  input wire logic [4:0] DTC_SEL,
  output logic [31:0] DTC_WORD,
  output logic [1:0] DTC_STATE
);
  localparam int NEV = `DFM_NUM_DEF * `DFM_EV_PER_DEF;

  // Reset synchroniser; only the second stage is used by the design.
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Bus decode: upper three bits pick the definition, low five the slot.
  wire [2:0] a_def = REG_ADDR[7:5];
  wire [4:0] a_slot = REG_ADDR[4:0];

  // Millisecond tick; debounce delays and long timers count in it.
  // A shorter tick in the bench keeps runs brief; the logic is unchanged.
  logic [15:0] tick_cnt;
  wire tick = (tick_cnt == 16'(TICK_CYC - 1));
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt <= 16'h0000;
    else
      tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
  end

  // Per-definition setup and the value each one watches.
  dfm_defcfg_t defcfg [`DFM_NUM_DEF];
  logic [15:0] watched [`DFM_NUM_DEF];
  logic [`DFM_NUM_DEF-1:0] tc_load;
  genvar gd;
  generate
    for (gd = 0; gd < `DFM_NUM_DEF; gd++)
    begin : g_def
      // A write to the setup slot of this definition.
      wire wr_def = REG_WR && (a_def == 3'(gd)) && (a_slot == `DFM_SLOT_DEF);
      // Incoming setup word, viewed through the register layout.
      wire dfm_defcfg_t wcfg = dfm_defcfg_t'(REG_WDATA[7:0]);
      assign tc_load[gd] = wr_def && (wcfg.src == SRC_TC);
      assign watched[gd] = (defcfg[gd].src == SRC_TC) ? TC_TEMP[16*defcfg[gd].idx +: 16] :
                           (defcfg[gd].src == SRC_SUPPLY) ? SUPPLY_VALUE :
                           (defcfg[gd].src == SRC_CPU) ? CPU_TEMP :
                           (defcfg[gd].src == SRC_RXTO) ? {15'h0000, RX_TIMEOUT[defcfg[gd].idx]} :
                           16'h0000;
      // Setup register; defaults put supply, CPU and timeout first.
      always_ff @(posedge MCLK or negedge rst_n)
      begin
        if (!rst_n)
        begin
          defcfg[gd].src <= (gd == 0) ? SRC_SUPPLY : (gd == 1) ? SRC_CPU :
                            (gd == 2) ? SRC_RXTO : SRC_TC;
          defcfg[gd].idx <= (gd < 3) ? 3'h0 : 3'(gd - 3);
          defcfg[gd].ftype <= (gd == 2) ? FT_STATE : FT_MINMAX;
        end
        else if (wr_def)
          defcfg[gd] <= wcfg;
      end
    end
  endgenerate

  // Per-event state: thresholds, setup, debounce, flags and counts.
  logic [15:0] thr [NEV];
  dfm_evcfg_t evcfg [NEV];
  logic [15:0] delay [NEV];
  logic [15:0] dcnt [NEV];
  logic [6:0] occ [NEV];
  logic [NEV-1:0] act;
  logic [NEV-1:0] prev;
  logic [NEV-1:0] cond;
  logic [NEV-1:0] fire;
  genvar ge;
  generate
    for (ge = 0; ge < NEV; ge++)
    begin : g_ev
      // Owning definition and threshold position of this event.
      localparam int D = ge / 4;
      localparam int E = ge % 4;
      // Value under watch, shared by the four events of one definition.
      wire [15:0] v = watched[D];
      // Register writes aimed at this event's threshold, setup and delay.
      wire hit_def = (a_def == 3'(D));
      wire wr_thr = REG_WR && hit_def && (a_slot == 5'(`DFM_SLOT_THR + E));
      wire wr_cfg = REG_WR && hit_def && (a_slot == 5'(`DFM_SLOT_EVCFG + E));
      wire wr_dly = REG_WR && hit_def && (a_slot == 5'(`DFM_SLOT_DELAY + E));
      wire dfm_evcfg_t wev = dfm_evcfg_t'(REG_WDATA[27:0]);
      // only codes 0..21 and 31 are taken
      wire fmi_ok = (wev.fmi <= `DFM_FMI_LAST_STD) || (wev.fmi == `DFM_FMI_EXISTS);
      wire [18:0] tc_spn = TC_SPN[19*REG_WDATA[5:3] +: 19];
      // all events of the definition take the channel SPN
      wire [18:0] next_spn = tc_load[D] ? tc_spn : (wr_cfg && fmi_ok) ? wev.spn : evcfg[ge].spn;
      // zero SPN or disabled code generation never reports
      wire en = evcfg[ge].gen && (evcfg[ge].spn != 19'h00000);
      // fault type decides how each threshold is judged
      // at or above the one threshold
      // two low then two high levels
      wire raw = (defcfg[D].ftype == FT_MINMAX) ? ((E == 0) ? (v < thr[ge]) :
                                                   (E == 1) ? (v > thr[ge]) : 1'b0) :
                 (defcfg[D].ftype == FT_ABS) ? ((E == 0) && (v >= thr[ge])) :
                 (defcfg[D].ftype == FT_STATE) ? ((E == 0) && (v != 16'h0000)) :
                 ((E < 2) ? (v < thr[ge]) : (v > thr[ge]));
      assign cond[ge] = raw && en;
      // debounce expired on a still-present fault
      assign fire[ge] = cond[ge] && !act[ge] && (dcnt[ge] == delay[ge]);
      // Setup, debounce and status of one event.
      always_ff @(posedge MCLK or negedge rst_n)
      begin
        if (!rst_n)
        begin
          thr[ge] <= 16'h0000;
          evcfg[ge] <= '{latch: 1'b0, gen: 1'b0, lamp: `DFM_LAMP_AMBER,
                         fmi: `DFM_FMI_DEFAULT, spn: 19'h00000};
          delay[ge] <= 16'h0000;
          dcnt[ge] <= 16'h0000;
          occ[ge] <= 7'h00;
          act[ge] <= 1'b0;
          prev[ge] <= 1'b0;
        end
        else
        begin
          if (wr_thr)
            thr[ge] <= REG_WDATA[15:0];
          if (wr_dly)
            delay[ge] <= REG_WDATA[15:0];
          if (wr_cfg && fmi_ok)
            evcfg[ge] <= wev;
          evcfg[ge].spn <= next_spn;
          // Debounce counts only while the fault stays present.
          if (!cond[ge] || act[ge])
            dcnt[ge] <= 16'h0000;
          else if (tick && (dcnt[ge] != delay[ge]))
            dcnt[ge] <= dcnt[ge] + 16'h0001;
          if (CLR_PREV_REQ)
            prev[ge] <= 1'b0;
          // only the active clear drops a latched code
          if (CLR_ACTIVE_REQ && act[ge])
          begin
            act[ge] <= 1'b0;
            prev[ge] <= 1'b1;
          end
          // condition gone, code becomes previously active
          if (act[ge] && !cond[ge] && !evcfg[ge].latch)
          begin
            act[ge] <= 1'b0;
            prev[ge] <= 1'b1;
          end
          // count saturates so it never wraps to zero
          if (fire[ge])
          begin
            act[ge] <= 1'b1;
            occ[ge] <= (occ[ge] == `DFM_OC_MAX) ? occ[ge] : occ[ge] + 7'h01;
          end
          if (next_spn != evcfg[ge].spn)
            occ[ge] <= 7'h00;
        end
      end
    end
  endgenerate

  // Counts of active and previous codes, and the lamp bytes they light.
  logic [4:0] n_act;
  logic [4:0] n_prev;
  logic [7:0] lamp_act;
  logic [7:0] lamp_prev;
  always_comb
  begin
    n_act = 5'h00;
    n_prev = 5'h00;
    lamp_act = 8'h00;
    lamp_prev = 8'h00;
    // Five bits hold all twenty-four events, so the sums never wrap.
    for (int i = 0; i < NEV; i++)
    begin
      n_act = n_act + {4'h0, act[i]};
      n_prev = n_prev + {4'h0, prev[i]};
      // each lamp owns a two-bit field, 01 means on
      if (act[i])
        lamp_act[2*evcfg[i].lamp] = 1'b1;
      if (prev[i])
        lamp_prev[2*evcfg[i].lamp] = 1'b1;
    end
  end

  // Power-up hold and periodic broadcast timers, both in milliseconds.
  logic [15:0] hold_cnt;
  logic hold_done;
  logic [15:0] per_cnt;
  logic [NEV-1:0] act_d;
  logic pend_act;
  logic pend_prev;
  // periodic broadcast, also when nothing is active
  wire per_due = tick && (per_cnt == 16'(PERIOD_MS - 1));
  wire rose = |(act & ~act_d);
  // the last active code went away
  wire went_idle = (|act_d) && !(|act);
  // An acknowledge only counts for the kind of list that is on show.
  wire ack_act = MSG_ACK && MSG.valid && (MSG.kind == MSG_ACTIVE);
  wire ack_prev = MSG_ACK && MSG.valid && (MSG.kind == MSG_PREV);
  // no active list goes out before the hold ends
  wire set_act = hold_done && (rose || went_idle || per_due);
  // A new cause wins over an acknowledge in the same cycle.
  wire next_pend_act = (pend_act && !ack_act) || set_act;
  wire next_pend_prev = (pend_prev && !ack_prev) || PREV_LIST_REQ;

  // Timers, edge history and pending message flags.
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_cnt <= 16'h0000;
      hold_done <= 1'b0;
      per_cnt <= 16'h0000;
      act_d <= '0;
      pend_act <= 1'b0;
      pend_prev <= 1'b0;
    end
    else
    begin
      // The hold counter stops once the hold has ended, so it cannot wrap.
      if (tick && !hold_done)
        hold_cnt <= hold_cnt + 16'h0001;
      if (hold_cnt == 16'(HOLD_MS))
        hold_done <= 1'b1;
      // The period restarts whenever an immediate message is queued.
      // It also wraps on its own while the hold runs, so that a long hold
      // cannot push the counter past the period and stall the broadcast.
      if (set_act || per_due)
        per_cnt <= 16'h0000;
      else if (tick)
        per_cnt <= per_cnt + 16'h0001;
      act_d <= act;
      pend_act <= next_pend_act;
      pend_prev <= next_pend_prev;
    end
  end

  // Message request register; the active list has priority.
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
      MSG <= '0;
    else if (next_pend_act)
      // more than one code needs the transport protocol
      MSG <= '{valid: 1'b1, kind: MSG_ACTIVE, tp: (n_act > 5'h01),
               lamp: lamp_act, count: n_act};
    else
      MSG <= '{valid: next_pend_prev, kind: MSG_PREV, tp: (n_prev > 5'h01),
               lamp: lamp_prev, count: n_prev};
  end

  // four-byte code: SPN low, SPN mid, SPN high with FMI, CM and OC
  wire dfm_evcfg_t sel_cfg = evcfg[DTC_SEL];
  wire [31:0] sel_word = {1'b0, occ[DTC_SEL], sel_cfg.spn[18:16], sel_cfg.fmi,
                          sel_cfg.spn[15:8], sel_cfg.spn[7:0]};

  // Code readout for the transmit side, one cycle after the index.
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      DTC_WORD <= 32'h00000000;
      DTC_STATE <= 2'h0;
    end
    else
    begin
      DTC_WORD <= (DTC_SEL < 5'(NEV)) ? sel_word : 32'h00000000;
      DTC_STATE <= (DTC_SEL < 5'(NEV)) ? {prev[DTC_SEL], act[DTC_SEL]} : 2'h0;
    end
  end

  // Register read mux; unmapped addresses read zero.
  // Slots of one kind repeat every four addresses, so the low two bits
  // of the slot, less the first slot, give the event within the definition.
  wire [2:0] r_ev_sub = a_slot[1:0] - 2'(`DFM_SLOT_THR);
  wire [4:0] r_ev = {a_def[2:0], 2'h0} + {3'h0, r_ev_sub[1:0]};
  wire [4:0] r_base = {a_def[2:0], 2'h0};
  wire def_ok = (a_def < 3'(`DFM_NUM_DEF));
  wire in_thr = (a_slot >= `DFM_SLOT_THR) && (a_slot < `DFM_SLOT_EVCFG);
  wire in_cfg = (a_slot >= `DFM_SLOT_EVCFG) && (a_slot < `DFM_SLOT_DELAY);
  wire in_dly = (a_slot >= `DFM_SLOT_DELAY) && (a_slot < `DFM_SLOT_STAT);
  wire in_oc = (a_slot >= `DFM_SLOT_OC) && (a_slot < 5'(`DFM_SLOT_OC + 4));
  wire [4:0] r_oc = r_base + {3'h0, a_slot[1:0] - 2'(`DFM_SLOT_OC)};
  wire [31:0] rd_mux =
    (REG_ADDR == `DFM_GLOBAL_ADDR) ? {26'h0000000, hold_done, n_act} :
    !def_ok ? 32'h00000000 :
    (a_slot == `DFM_SLOT_DEF) ? {24'h000000, defcfg[a_def]} :
    in_thr ? {16'h0000, thr[r_ev]} :
    in_cfg ? {4'h0, evcfg[r_ev]} :
    in_dly ? {16'h0000, delay[r_ev]} :
    (a_slot == `DFM_SLOT_STAT) ? {20'h00000, cond[r_base +: 4], prev[r_base +: 4],
                                  act[r_base +: 4]} :
    in_oc ? {25'h0000000, occ[r_oc]} : 32'h00000000;

  // Read data stand for one cycle after the read strobe, zero otherwise.
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
      REG_RDATA <= 32'h00000000;
    else
      REG_RDATA <= REG_RD ? rd_mux : 32'h00000000;
  end
endmodule

// ==== dv/dfm_chk.sv ====
// Port-level assertions for the fault monitor.
`timescale 1ns/10ps
module dfm_chk
  import dfm_pkg::*;
#(
  parameter int TICK_CYC = 4,
  parameter int HOLD_MS = 3
)(
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic PREV_LIST_REQ,
  input wire dfm_msg_t MSG,
  input wire logic MSG_ACK,
  input wire logic [4:0] DTC_SEL,
  input wire logic [31:0] DTC_WORD,
  input wire logic [1:0] DTC_STATE
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!ARST_N);
  // Cycles since release; it stops at the end of the quiet window, so the
  // window never reopens and never ends early for a long hold.
  int up;
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
      up <= 32'h0;
    else if (up < HOLD_MS * TICK_CYC)
      up <= up + 32'h1;
  end
  a_hold_quiet: assert property (
    up < HOLD_MS * TICK_CYC |-> !(MSG.valid && MSG.kind == MSG_ACTIVE)) else $error("early list");
  a_msg_stands: assert property (MSG.valid && !MSG_ACK |=> MSG.valid)
    else $error("message dropped unacked");
  a_tp_multi: assert property (MSG.valid |-> MSG.tp == (MSG.count > 5'h01))
    else $error("transport flag wrong");
  a_idle_lamp: assert property (
    MSG.valid && MSG.kind == MSG_ACTIVE && MSG.count == 5'h00 |-> MSG.lamp == 8'h00)
    else $error("lamp set with no codes");
  a_sel_range: assert property (
    DTC_SEL >= 5'h18 |=> DTC_WORD == 32'h0 && DTC_STATE == 2'h0) else $error("bad event index");
  a_fmi_legal: assert property (
    DTC_WORD[20:16] <= 5'h15 || DTC_WORD[20:16] == 5'h1F) else $error("illegal failure mode");
  a_zero_spn: assert property (
    DTC_WORD[23:21] == 3'h0 && DTC_WORD[15:0] == 16'h0 |-> !DTC_STATE[0])
    else $error("zero number active");
  a_prev_reply: assert property (
    $rose(PREV_LIST_REQ) |-> ##[1:40] MSG.valid && MSG.kind == MSG_PREV)
    else $error("no previous list");
  a_cm_zero: assert property (DTC_WORD[31] == 1'b0) else $error("method bit set");
  c_multi: cover property (MSG.valid && MSG.tp);
  c_prev: cover property (MSG.valid && MSG.kind == MSG_PREV);
  c_was: cover property (DTC_STATE == 2'h2);
endmodule
bind dfm_monitor dfm_chk #(.TICK_CYC(TICK_CYC), .HOLD_MS(HOLD_MS)) u_chk (
  .MCLK(MCLK), .ARST_N(ARST_N), .PREV_LIST_REQ(PREV_LIST_REQ), .MSG(MSG), .MSG_ACK(MSG_ACK),
  .DTC_SEL(DTC_SEL), .DTC_WORD(DTC_WORD), .DTC_STATE(DTC_STATE)
);

// ==== dv/dfm_net.sv ====
// Network-side model: acknowledges message requests after a chosen delay.
`timescale 1ns/10ps
module dfm_net
  import dfm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire dfm_msg_t msg,
  input wire logic [1:0] dly,
  output logic ack
);
  // Cycles the pending frame has waited for the bus.
  logic [1:0] wt;
  // One pulse per frame; a long delay mimics a crowded bus.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack <= 1'b0;
      wt <= 2'h0;
    end
    else if (ack || !msg.valid)
    begin
      ack <= 1'b0;
      wt <= 2'h0;
    end
    else if (wt >= dly)
      ack <= 1'b1;
    else
      wt <= wt + 2'h1;
  end
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the fault monitor.
`timescale 1ns/10ps
module tb_top
  import dfm_pkg::*;
;
  logic MCLK = 1'b0;
  logic ARST_N = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [15:0] SUPPLY_VALUE = 16'h0800;
  logic [15:0] CPU_TEMP = 16'h0;
  logic [7:0] RX_TIMEOUT = 8'h00;
  logic [95:0] TC_TEMP = 96'h0;
  logic [113:0] TC_SPN = 114'h0;
  logic CLR_ACTIVE_REQ = 1'b0;
  logic CLR_PREV_REQ = 1'b0;
  logic PREV_LIST_REQ = 1'b0;
  logic [4:0] DTC_SEL = 5'h00;
  logic [1:0] dly = 2'h0;
  logic [31:0] REG_RDATA;
  logic [31:0] DTC_WORD;
  logic [1:0] DTC_STATE;
  logic MSG_ACK;
  dfm_msg_t MSG;
  int error_cnt = 0;
  int check_count = 0;
  // Fixed start value keeps every run identical.
  logic [31:0] rng = 32'h0000004C;
  logic [18:0] spn_a;
  logic [18:0] spn_b;
  int ch;
  // Short tick, hold and period keep the run brief.
  dfm_monitor #(.TICK_CYC(4), .HOLD_MS(3), .PERIOD_MS(5)) dut (
    .MCLK(MCLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SUPPLY_VALUE(SUPPLY_VALUE),
    .CPU_TEMP(CPU_TEMP), .RX_TIMEOUT(RX_TIMEOUT), .TC_TEMP(TC_TEMP), .TC_SPN(TC_SPN),
    .CLR_ACTIVE_REQ(CLR_ACTIVE_REQ), .CLR_PREV_REQ(CLR_PREV_REQ),
    .PREV_LIST_REQ(PREV_LIST_REQ), .MSG(MSG), .MSG_ACK(MSG_ACK), .DTC_SEL(DTC_SEL),
    .DTC_WORD(DTC_WORD), .DTC_STATE(DTC_STATE)
  );
  dfm_net net (.clk(MCLK), .rst_n(ARST_N), .msg(MSG), .dly(dly), .ack(MSG_ACK));
  // A 40 ns clock.
  always #20 MCLK = ~MCLK;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Event setup word as laid out in its register.
  function automatic logic [31:0] evw(input logic l, input logic g, input logic [1:0] lp,
    input logic [4:0] f, input logic [18:0] s);
    return {4'h0, l, g, lp, f, s};
  endfunction
  // Trouble code word; the method bit is always zero.
  function automatic logic [31:0] dtcw(input logic [18:0] s, input logic [4:0] f,
    input logic [6:0] oc);
    return {1'b0, oc, s[18:16], f, s[15:8], s[7:0]};
  endfunction
  task automatic test_done();
    if (error_cnt == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_st(input logic [1:0] got, input logic [1:0] exp);
    chk_reg({30'h0, got}, {30'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge MCLK);
    REG_WR <= 1'b0;
    // One idle edge, so a following write never lowers and raises the strobe at once.
    @(posedge MCLK);
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1;
    chk_reg(REG_RDATA, exp);
    @(posedge MCLK);
  endtask
  task automatic dtc(input logic [4:0] sel, input logic [31:0] w, input logic [1:0] st);
    DTC_SEL <= sel;
    @(posedge MCLK);
    #1;
    chk_reg(DTC_WORD, w);
    chk_st(DTC_STATE, st);
    @(posedge MCLK);
  endtask
  // Waits, bounded, for an active list and checks its count and lamp byte.
  task automatic wait_msg(input logic [4:0] cnt, input logic [7:0] lamp, input int lim);
    int n;
    n = 0;
    // Two edges let the cause reach MSG; a third could miss a quick acknowledge.
    repeat (2) @(posedge MCLK);
    do
    begin
      @(negedge MCLK);
      n++;
    end while ((MSG.valid && MSG.kind == MSG_ACTIVE) !== 1'b1 && n < lim);
    if ((MSG.valid && MSG.kind == MSG_ACTIVE) !== 1'b1)
    begin
      // A list that never shows ends the run as a mismatch.
      chk_reg(32'h0, 32'h1);
      test_done();
    end
    else
    begin
      chk_reg({19'h0, MSG.lamp, MSG.count}, {19'h0, lamp, cnt});
      @(posedge MCLK);
    end
  endtask
  // One-cycle request: 0 active clear, 1 previous list, 2 previous clear.
  task automatic pulse(input int w);
    CLR_ACTIVE_REQ <= (w == 0);
    PREV_LIST_REQ <= (w == 1);
    CLR_PREV_REQ <= (w == 2);
    @(posedge MCLK);
    CLR_ACTIVE_REQ <= 1'b0;
    PREV_LIST_REQ <= 1'b0;
    CLR_PREV_REQ <= 1'b0;
  endtask
  // Watchdog: a hang counts as a mismatch.
  initial
  begin
    repeat (4000) @(posedge MCLK);
    chk_reg(32'h0, 32'h1);
    test_done();
  end
  initial
  begin
    for (int i = 0; i < 6; i++)
    begin
      rng = xs(rng);
      TC_SPN[19*i +: 19] = rng[18:0];
      TC_TEMP[16*i +: 16] = rng[31:16];
    end
    CPU_TEMP = rng[15:0] | 16'h0001;
    repeat (2) @(posedge MCLK);
    ARST_N <= 1'b1;
    repeat (3) @(posedge MCLK);
    rd(8'h00, 32'h2);
    rd(8'h20, 32'h3);
    rd(8'h40, 32'h84);
    rd(8'h05, evw(0, 0, 2'h1, 5'h1F, 19'h0));
    rd(8'hC0, 32'h0);
    wait_msg(5'h00, 8'h00, 30);
    for (int t = 0; t < 4; t++)
    begin
      wr(8'hA0, 32'h2 | (t << 6));
      rd(8'hA0, 32'h2 | (t << 6));
    end
    rng = xs(rng);
    ch = rng % 6;
    wr(8'h60, 32'h1 | (ch << 3));
    for (int k = 0; k < 4; k++)
      rd(8'(8'h65 + k), evw(0, 0, 2'h1, 5'h1F, TC_SPN[19*ch +: 19]));
    wr(8'h05, evw(0, 1, 2'h1, 5'h16 + 5'(rng[2:0]), 19'h5));
    rd(8'h05, evw(0, 0, 2'h1, 5'h1F, 19'h0));
    dtc(5'h18 + 5'(rng[2:0]), 32'h0, 2'h0);
    spn_a = rng[18:0] | 19'h1;
    spn_b = rng[31:13] | 19'h2;
    wr(8'h02, 32'h1000);
    wr(8'h06, evw(0, 1, 2'h2, 5'h00, spn_a));
    wr(8'h45, evw(1, 1, 2'h0, 5'h1F, spn_b));
    wr(8'h26, evw(0, 1, 2'h1, 5'h00, 19'h0));
    SUPPLY_VALUE <= 16'h1000;
    repeat (3) @(posedge MCLK);
    dtc(5'h01, dtcw(spn_a, 5'h00, 7'h0), 2'h0);
    dly <= rng[1:0];
    SUPPLY_VALUE <= 16'h1001 + 16'(rng[11:0]);
    wait_msg(5'h01, 8'h10, 10);
    dtc(5'h01, dtcw(spn_a, 5'h00, 7'h1), 2'h1);
    RX_TIMEOUT <= 8'h01;
    wait_msg(5'h02, 8'h11, 10);
    RX_TIMEOUT <= 8'h00;
    SUPPLY_VALUE <= 16'h0800;
    wait_msg(5'h01, 8'h01, 30);
    dtc(5'h01, dtcw(spn_a, 5'h00, 7'h1), 2'h2);
    dtc(5'h08, dtcw(spn_b, 5'h1F, 7'h1), 2'h1);
    dly <= rng[3:2];
    pulse(0);
    wait_msg(5'h00, 8'h00, 10);
    rd(8'hE0, 32'h20);
    pulse(1);
    repeat (20) @(posedge MCLK);
    pulse(2);
    repeat (2) @(posedge MCLK);
    rd(8'h0D, 32'h0);
    wr(8'h06, evw(0, 1, 2'h2, 5'h00, spn_a ^ 19'h100));
    dtc(5'h01, dtcw(spn_a ^ 19'h100, 5'h00, 7'h0), 2'h0);
    wr(8'h49, 32'h3);
    RX_TIMEOUT <= 8'h01;
    repeat (2) @(posedge MCLK);
    rd(8'h4D, 32'h100);
    repeat (16) @(posedge MCLK);
    rd(8'h4D, 32'h101);
    // Definition six still watches the supply in double mode; its fourth level trips.
    wr(8'hA8, evw(0, 1, 2'h1, 5'h00, 19'h7));
    rd(8'hAD, 32'h808);
    // Absolute mode: only the first level is judged, the fourth goes previous.
    wr(8'hA0, 32'h42);
    wr(8'hA5, evw(0, 1, 2'h1, 5'h01, 19'h7));
    rd(8'hAD, 32'h181);
    test_done();
  end
endmodule
